// >>> core/ptmr_core.v
// periodic timer: 10-bit counter, comparators a and p, four modes, apb slave
//
// Behaviour
// - mode_select picks compare-match, capture, pwm/single pulse or timer/counter mode
// - compare mode, clear_select low: clear on p match or overflow; both flags
// - compare mode, clear_select high: clear on a match; only flag a raised
// - compare_a_value zero: counter overflows at 3ff, flag a not raised
// - compare mode: pin changes on comparator a match and counter_on rise; code 00 no change on match
// - compare mode: counter_on rising edge drives pin to output_initial_level
// - timer/counter mode acts like compare mode but does not drive pin
// - pwm ignores clear_select; p match clears counter, a sets duty
// - pwm period equals compare_p_value, or 1024 counts when it is zero
// - duty value at or above period gives full duty output
// - pwm raises flag a on a match and flag p on p match
// - pwm: initial level sets active level, function enables or forces, invert flips
// - pwm counting and compares keep running while function is 00 or 01
// - single pulse is pwm mode with function 11; counter_on rise starts pulse
// - single pulse: external clock pin edge sets counter_on automatically
// - pulse ends on counter_on clear or a match; a match clears counter_on
// - single pulse: counter zeroed only on counter_on rise; p and clear_select unused
// - capture mode: source select picks pin; counter starts on counter_on rise
// - capture edge copies counter into compare_a_value and raises interrupt
// - capture mode: p match resets counter and raises interrupt
// - capture mode with function 11 performs no capture; counter still runs
// - counter and compare values are 10 bits in low byte plus two high bits
// - compare mode function: 00 none, 01 low, 10 high, 11 toggle
// - pwm function: 00 inactive, 01 active, 10 waveform, 11 single pulse
// - capture source: 0 capture input pin, 1 external clock pin
// - capture edge: 00 rising, 01 falling, 10 both, 11 disabled
//
// Register access over APB and the address map are this design's own decisions.
`include "ptmr_defs.vh"

module ptmr_core (
    input wire sys_clk_in,              // 40 mhz system clock
    input wire reset_n_in,              // async reset, active low
    input wire psel_in,                 // apb select
    input wire penable_in,              // apb enable
    input wire pwrite_in,               // apb direction, high for write
    input wire [11:0] paddr_in,         // apb byte address
    input wire [31:0] pwdata_in,        // apb write data
    output reg [31:0] prdata_out,       // apb read data
    output reg pready_out,              // apb ready
    output reg pslverr_out,             // apb error, unmapped address
    input wire capture_input_pin_in,    // capture pin, asynchronous
    input wire external_clock_pin_in,   // external clock pin, asynchronous
    output reg timer_out_out,           // timer output pin level
    output reg timer_out_oe_out,        // timer output pin enable
    output reg timer_event_out          // one-cycle pulse on any timer interrupt event
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACCESS = 2'b10;

    reg [1:0] bus_state_reg;

    // control fields
    reg counter_on_reg;
    reg [1:0] mode_select_reg;
    reg [1:0] output_function_reg;
    reg output_initial_level_reg;
    reg output_invert_reg;
    reg capture_source_select_reg;
    reg clear_select_reg;

    // count and compare values
    reg [9:0] counter_reg;
    reg [9:0] compare_a_value_reg;
    reg [9:0] compare_p_value_reg;

    // flags, pin and edge history
    reg match_a_flag_reg;
    reg match_p_flag_reg;
    reg pin_level_reg;
    reg on_prev_reg;
    reg [2:0] cap_sync_reg;
    reg [2:0] ext_sync_reg;

    // ------------------------------------------------------------------------
    // pin synchronisers: bit0 feeds bit1 only, edges from bits 1 and 2
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cap_sync_reg <= 3'h0;
            ext_sync_reg <= 3'h0;
        end else begin
            cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin_in};
            ext_sync_reg <= {ext_sync_reg[1:0], external_clock_pin_in};
        end
    end

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function edge_hit;
        input [1:0] ofn;
        input now_lvl;
        input old_lvl;
        begin
            case (ofn)
                `PTMR_OFN_00: edge_hit = now_lvl & ~old_lvl;
                `PTMR_OFN_01: edge_hit = ~now_lvl & old_lvl;
                `PTMR_OFN_10: edge_hit = now_lvl ^ old_lvl;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    function [7:0] hi_byte;
        input [9:0] val;
        begin
            hi_byte = {6'h00, val[9:8]};
        end
    endfunction

    // bus strobes and mode decode
    wire bus_write = psel_in & penable_in & pwrite_in & (bus_state_reg == ST_ACCESS);
    wire mode_cmp_like = (mode_select_reg == `PTMR_MODE_CMP) || (mode_select_reg == `PTMR_MODE_TMR);
    wire mode_pwm = (mode_select_reg == `PTMR_MODE_PWM);
    wire mode_cap = (mode_select_reg == `PTMR_MODE_CAP);
    wire single_pulse = mode_pwm && (output_function_reg == `PTMR_OFN_11);

    wire ctrl0_wr = bus_write && (paddr_in == `PTMR_CTRL0_ADDR);
    wire on_written = pwdata_in[`PTMR_ON_BIT];

    // synchronised pin edges
    wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
    wire src_now = capture_source_select_reg ? ext_sync_reg[1] : cap_sync_reg[1];
    wire src_old = capture_source_select_reg ? ext_sync_reg[2] : cap_sync_reg[2];
    wire on_rise = counter_on_reg & ~on_prev_reg;

    wire a_zero = (compare_a_value_reg == 10'h000);
    wire p_zero = (compare_p_value_reg == 10'h000);
    wire at_max = (counter_reg == `PTMR_CNT_MAX);
    wire run = counter_on_reg & ~on_rise;

    // compare a: in compare mode a zero value never matches, overflow instead
    wire a_match = run && (mode_cmp_like ? (!a_zero && counter_reg == compare_a_value_reg - 10'h001)
                                          : (counter_reg + 10'h001 == compare_a_value_reg));
    // compare p: zero means full 1024-count span
    wire p_match = run && (p_zero ? at_max : (counter_reg + 10'h001 == compare_p_value_reg));
    wire cap_hit = run && mode_cap && edge_hit(output_function_reg, src_now, src_old);

    // ------------------------------------------------------------------------
    // counter, clearing and flags
    // ------------------------------------------------------------------------
    reg [9:0] counter_next;
    reg flag_a_set;
    reg flag_p_set;
    reg on_auto_clear;

    always @* begin
        counter_next = counter_reg;
        flag_a_set = 1'b0;
        flag_p_set = 1'b0;
        on_auto_clear = 1'b0;

        if (on_rise) begin
            counter_next = 10'h000;
        end else if (counter_on_reg) begin
            counter_next = counter_reg + 10'h001;
            if (mode_cmp_like) begin
                if (clear_select_reg) begin
                    flag_a_set = a_match;
                    if (a_match || (a_zero && at_max)) begin
                        counter_next = 10'h000;
                    end
                end else begin
                    flag_a_set = a_match;
                    flag_p_set = p_match;
                    if (p_match) begin
                        counter_next = 10'h000;
                    end
                end
            end else if (single_pulse) begin
                flag_a_set = a_match;
                if (a_match) begin
                    on_auto_clear = 1'b1;
                end
            end else if (mode_pwm) begin
                flag_a_set = a_match;
                flag_p_set = p_match;
                if (p_match) begin
                    counter_next = 10'h000;
                end
            end else begin
                flag_a_set = cap_hit;
                flag_p_set = p_match;
                if (p_match) begin
                    counter_next = 10'h000;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------------------
    reg pin_next;
    reg active_lvl;
    reg pin_drive;
    always @* begin
        pin_next = pin_level_reg;
        active_lvl = output_initial_level_reg;
        pin_drive = pin_level_reg;

        if (on_rise) begin
            pin_next = mode_pwm ? ~output_initial_level_reg : output_initial_level_reg;
        end

        if (mode_cmp_like) begin
            if (flag_a_set && mode_select_reg == `PTMR_MODE_CMP) begin
                case (output_function_reg)
                    `PTMR_OFN_01: pin_next = 1'b0;
                    `PTMR_OFN_10: pin_next = 1'b1;
                    `PTMR_OFN_11: pin_next = ~pin_level_reg;
                    default: pin_next = pin_level_reg;
                endcase
            end
            pin_drive = pin_next ^ output_invert_reg;
        end else if (mode_pwm) begin
            case (output_function_reg)
                `PTMR_OFN_00: pin_next = ~active_lvl;
                `PTMR_OFN_01: pin_next = active_lvl;
                `PTMR_OFN_10: begin
                    // full duty when duty value reaches period
                    if (!counter_on_reg) begin
                        pin_next = ~active_lvl;
                    end else if (!a_zero && ({1'b0, compare_a_value_reg} >=
                                 (p_zero ? 11'h400 : {1'b0, compare_p_value_reg}))) begin
                        pin_next = active_lvl;
                    end else begin
                        pin_next = (counter_next < compare_a_value_reg) ? active_lvl : ~active_lvl;
                    end
                end
                default: pin_next = (counter_on_reg && !on_auto_clear && !ctrl0_wr) ? active_lvl
                                    : ((ctrl0_wr && on_written) ? active_lvl : ~active_lvl);
            endcase
            pin_drive = pin_next ^ output_invert_reg;
        end
    end

    // ------------------------------------------------------------------------
    // registers and apb slave
    // ------------------------------------------------------------------------
    wire [31:0] ctrl0_rd = {24'h000000, 4'h0, counter_on_reg, 3'h0};
    wire [31:0] ctrl1_rd = {24'h000000, mode_select_reg, output_function_reg, output_initial_level_reg,
                            output_invert_reg, capture_source_select_reg, clear_select_reg};
    reg [31:0] rd_mux;
    reg addr_ok;
    always @* begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b1;

        case (paddr_in)
            `PTMR_CTRL0_ADDR: rd_mux = ctrl0_rd;
            `PTMR_CTRL1_ADDR: rd_mux = ctrl1_rd;
            `PTMR_CNT_LO_ADDR: rd_mux = {24'h000000, counter_reg[7:0]};
            `PTMR_CNT_HI_ADDR: rd_mux = {24'h000000, hi_byte(counter_reg)};
            `PTMR_CMPA_LO_ADDR: rd_mux = {24'h000000, compare_a_value_reg[7:0]};
            `PTMR_CMPA_HI_ADDR: rd_mux = {24'h000000, hi_byte(compare_a_value_reg)};
            `PTMR_CMPP_LO_ADDR: rd_mux = {24'h000000, compare_p_value_reg[7:0]};
            `PTMR_CMPP_HI_ADDR: rd_mux = {24'h000000, hi_byte(compare_p_value_reg)};
            `PTMR_FLAGS_ADDR: rd_mux = {30'h00000000, match_p_flag_reg, match_a_flag_reg};
            default: addr_ok = 1'b0;
        endcase
    end

    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_state_reg <= ST_IDLE;
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;

            counter_on_reg <= 1'b0;
            on_prev_reg <= 1'b0;
            mode_select_reg <= 2'b00;
            output_function_reg <= 2'b00;
            output_initial_level_reg <= 1'b0;
            output_invert_reg <= 1'b0;
            capture_source_select_reg <= 1'b0;
            clear_select_reg <= 1'b0;

            counter_reg <= 10'h000;
            compare_a_value_reg <= 10'h000;
            compare_p_value_reg <= 10'h000;
            match_a_flag_reg <= 1'b0;
            match_p_flag_reg <= 1'b0;

            pin_level_reg <= 1'b0;
            timer_out_out <= 1'b0;
            timer_out_oe_out <= 1'b0;
            timer_event_out <= 1'b0;
        end else begin
            // bus: setup cycle, then one access cycle with ready high
            case (bus_state_reg)
                ST_IDLE: begin
                    pready_out <= 1'b0;
                    pslverr_out <= 1'b0;
                    if (psel_in && !penable_in) begin
                        bus_state_reg <= ST_ACCESS;
                        pready_out <= 1'b1;
                        pslverr_out <= ~addr_ok;
                        prdata_out <= pwrite_in ? 32'h00000000 : rd_mux;
                    end
                end
                ST_ACCESS: begin
                    bus_state_reg <= ST_IDLE;
                    pready_out <= 1'b0;
                    pslverr_out <= 1'b0;
                end
                default: bus_state_reg <= ST_IDLE;
            endcase

            if (bus_write && paddr_in == `PTMR_CTRL1_ADDR) begin
                mode_select_reg <= pwdata_in[`PTMR_MODE_HI:`PTMR_MODE_LO];
                output_function_reg <= pwdata_in[`PTMR_OFN_HI:`PTMR_OFN_LO];
                output_initial_level_reg <= pwdata_in[`PTMR_INIT_BIT];
                output_invert_reg <= pwdata_in[`PTMR_INV_BIT];
                capture_source_select_reg <= pwdata_in[`PTMR_CSRC_BIT];
                clear_select_reg <= pwdata_in[`PTMR_CLR_BIT];
            end

            if (bus_write && paddr_in == `PTMR_CMPP_LO_ADDR) begin
                compare_p_value_reg[7:0] <= pwdata_in[7:0];
            end
            if (bus_write && paddr_in == `PTMR_CMPP_HI_ADDR) begin
                compare_p_value_reg[9:8] <= pwdata_in[1:0];
            end

            // capture wins over a software write
            if (cap_hit) begin
                compare_a_value_reg <= counter_reg;
            end else if (bus_write && paddr_in == `PTMR_CMPA_LO_ADDR) begin
                compare_a_value_reg[7:0] <= pwdata_in[7:0];
            end else if (bus_write && paddr_in == `PTMR_CMPA_HI_ADDR) begin
                compare_a_value_reg[9:8] <= pwdata_in[1:0];
            end

            // counter_on: hardware set/clear wins over software write
            if (single_pulse && ext_rise) begin
                counter_on_reg <= 1'b1;
            end else if (on_auto_clear) begin
                counter_on_reg <= 1'b0;
            end else if (ctrl0_wr) begin
                counter_on_reg <= on_written;
            end

            on_prev_reg <= counter_on_reg;
            counter_reg <= counter_next;

            // flags: write one to clear, a set in the same cycle wins
            if (flag_a_set) begin
                match_a_flag_reg <= 1'b1;
            end else if (bus_write && paddr_in == `PTMR_FLAGS_ADDR && pwdata_in[`PTMR_FLAG_A_BIT]) begin
                match_a_flag_reg <= 1'b0;
            end
            if (flag_p_set) begin
                match_p_flag_reg <= 1'b1;
            end else if (bus_write && paddr_in == `PTMR_FLAGS_ADDR && pwdata_in[`PTMR_FLAG_P_BIT]) begin
                match_p_flag_reg <= 1'b0;
            end
            timer_event_out <= flag_a_set | flag_p_set;

            pin_level_reg <= pin_next;
            timer_out_out <= pin_drive;
            // pin released in timer/counter and capture modes
            timer_out_oe_out <= (mode_select_reg == `PTMR_MODE_CMP) || mode_pwm;
        end
    end

endmodule

// >>> include/ptmr_defs.vh
// register offsets, field positions, reset values and codes of the periodic timer
`ifndef PTMR_DEFS_VH
`define PTMR_DEFS_VH

// ----------------------------------------------------------------------------
// register byte addresses (one aligned word each)
// ----------------------------------------------------------------------------
`define PTMR_CTRL0_ADDR 12'h000
`define PTMR_CTRL1_ADDR 12'h004
`define PTMR_CNT_LO_ADDR 12'h008
`define PTMR_CNT_HI_ADDR 12'h00c
`define PTMR_CMPA_LO_ADDR 12'h010
`define PTMR_CMPA_HI_ADDR 12'h014
`define PTMR_CMPP_LO_ADDR 12'h018
`define PTMR_CMPP_HI_ADDR 12'h01c
`define PTMR_FLAGS_ADDR 12'h020

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PTMR_ON_BIT 3
`define PTMR_MODE_HI 7
`define PTMR_MODE_LO 6
`define PTMR_OFN_HI 5
`define PTMR_OFN_LO 4
`define PTMR_INIT_BIT 3
`define PTMR_INV_BIT 2
`define PTMR_CSRC_BIT 1
`define PTMR_CLR_BIT 0
`define PTMR_FLAG_A_BIT 0
`define PTMR_FLAG_P_BIT 1

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define PTMR_BYTE_RESET 8'h00
`define PTMR_CNT_MAX 10'h3ff
`define PTMR_MODE_CMP 2'b00
`define PTMR_MODE_CAP 2'b01
`define PTMR_MODE_PWM 2'b10
`define PTMR_MODE_TMR 2'b11
`define PTMR_OFN_00 2'b00
`define PTMR_OFN_01 2'b01
`define PTMR_OFN_10 2'b10
`define PTMR_OFN_11 2'b11

`endif

// >>> tb/ptmr_pin_model.sv
// far-side pins of the timer: capture input and external clock
module ptmr_pin_model (
    input wire logic clk_in,    // bench clock
    output logic cap_pin_out,   // capture input pin
    output logic ext_pin_out    // external clock pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cap_pin_out = 1'b0;
        ext_pin_out = 1'b0;
    end
    // one high pulse on the chosen pin; hold sets how slow the far side is
    task automatic pulse(input bit ext, input int hold);
        @(posedge clk_in);
        if (ext) ext_pin_out <= 1'b1;
        else cap_pin_out <= 1'b1;
        repeat (hold) @(posedge clk_in);
        ext_pin_out <= 1'b0;
        cap_pin_out <= 1'b0;
    endtask
endmodule

// >>> tb/ptmr_core_props.sv
// port checker for the periodic timer
`include "ptmr_defs.vh"
module ptmr_core_props (
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire timer_out_out,
    input wire timer_out_oe_out
);
    logic [7:0] c1_reg;
    logic [1:0] age_reg;
    logic on_reg;
    wire wr_ok = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
    wire ctl0 = wr_ok && paddr_in == `PTMR_CTRL0_ADDR;
    wire ctl1 = wr_ok && paddr_in == `PTMR_CTRL1_ADDR;
    wire rise = ctl0 && pwdata_in[3] && !on_reg;
    wire mapped = paddr_in <= 12'h020 && paddr_in[1:0] == 2'b00;
    wire hi_rd = !pwrite_in && paddr_in[2] && paddr_in[4:3] != 2'b00;
    // shadow of the control bytes and cycles since the last control write
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            c1_reg <= 8'h00;
            age_reg <= 2'h0;
            on_reg <= 1'b0;
        end else begin
            if (ctl1) c1_reg <= pwdata_in[7:0];
            if (ctl0) on_reg <= pwdata_in[3];
            age_reg <= (ctl0 || ctl1) ? 2'h0 : (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
        end
    end
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_answer; psel_in && !penable_in |=> pready_out; endproperty
    a_answer: assert property (p_answer) else $error("setup not answered");
    property p_pulse; pready_out |-> psel_in && penable_in && !$past(penable_in) ##1 !pready_out; endproperty
    a_pulse: assert property (p_pulse) else $error("ready not one cycle");
    property p_err; pready_out |-> pslverr_out == !mapped; endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
    property p_errdata; pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0; endproperty
    a_errdata: assert property (p_errdata) else $error("refused read not zero");
    property p_hi; pready_out && hi_rd |-> prdata_out[7:2] == 6'h00; endproperty
    a_hi: assert property (p_hi) else $error("high byte unused bits set");
    property p_lo; pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0; endproperty
    a_lo: assert property (p_lo) else $error("read wider than a byte");
    property p_oe; age_reg == 2'h3 |-> timer_out_oe_out == !c1_reg[6]; endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong for mode");
    property p_force;
        age_reg == 2'h3 && on_reg && c1_reg[7:5] == 3'b100 |-> timer_out_out == (c1_reg[4] ~^ c1_reg[3]) ^ c1_reg[2];
    endproperty
    a_force: assert property (p_force) else $error("forced level wrong");
    property p_init;
        rise && c1_reg[7:6] == 2'b00 && age_reg == 2'h3 |-> ##[1:3] timer_out_out == (c1_reg[3] ^ c1_reg[2]);
    endproperty
    a_init: assert property (p_init) else $error("pin not at initial level");
    c_refused: cover property (pready_out && pslverr_out);
    c_pwm_on: cover property (rise && c1_reg[7:6] == 2'b10);
    c_capture: cover property (ctl1 && pwdata_in[7:6] == 2'b01);
endmodule
bind ptmr_core ptmr_core_props props_i (.sys_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .timer_out_out, .timer_out_oe_out);

// >>> tb/ptmr_core_tb_top.sv
// self-checking bench for the periodic timer
`include "ptmr_defs.vh"
module ptmr_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
    logic capture_input_pin_in, external_clock_pin_in, timer_out_out, timer_out_oe_out, timer_event_out;
    logic [11:0] paddr_in, ad;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [11:0] regs [10] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024};
    int bad_count = 0, comparisons = 0, hi, per, a, dut, ev = 0, e0;
    int mdl [logic [11:0]];
    bit [31:0] seed = 32'd14077;
    ptmr_core uut (.sys_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .capture_input_pin_in, .external_clock_pin_in, .timer_out_out,
        .timer_out_oe_out, .timer_event_out);
    ptmr_pin_model pins (.clk_in(sys_clk_in), .cap_pin_out(capture_input_pin_in), .ext_pin_out(external_clock_pin_in));
    always @(posedge sys_clk_in) ev <= ev + timer_event_out;
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] msk(input logic [11:0] ad_in);
        case (ad_in)
            12'h000: return 32'h08;
            12'h004, 12'h010, 12'h018: return 32'hff;
            12'h014, 12'h01c: return 32'h03;
            default: return 32'h0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input bit w, input logic [11:0] ad_in, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= ad_in;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do @(posedge sys_clk_in);
        while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] ad_in, input logic [31:0] d);
        apb(1'b1, ad_in, d);
        mdl[ad_in] = d & msk(ad_in);
    endtask
    task automatic start(input logic [7:0] c1, input int av, input int pv);
        wr(`PTMR_CTRL0_ADDR, 32'h0);
        wr(`PTMR_CTRL1_ADDR, {24'h0, c1});
        wr(`PTMR_CMPA_LO_ADDR, 32'(av & 255));
        wr(`PTMR_CMPA_HI_ADDR, 32'(av >> 8));
        wr(`PTMR_CMPP_LO_ADDR, 32'(pv & 255));
        wr(`PTMR_CMPP_HI_ADDR, 32'(pv >> 8));
        wr(`PTMR_FLAGS_ADDR, 32'h3);
        wr(`PTMR_CTRL0_ADDR, 32'h8);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        reset_n_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, err}, i == 9);
            mdl[regs[i]] = 0;
        end
        repeat (12) begin
            ad = regs[2 + rnd() % 6];
            wr(ad, rnd());
            apb(1'b0, ad, 32'h0);
            chk(rd, mdl[ad]);
        end
        $display("register test done");
        for (int k = 0; k < 4; k++) begin
            per = (k == 3) ? 1024 : 8 + rnd() % 40;
            a = (k == 2) ? per + rnd() % 4 : (k == 3) ? 300 : 1 + rnd() % (per - 1);
            dut = (a < per) ? a : per;
            start(8'ha8 | ((k == 1) ? 8'h04 : 8'h00), a, per % 1024);
            repeat (2 * per) @(negedge sys_clk_in);
            hi = 0;
            repeat (2 * per) begin
                @(negedge sys_clk_in);
                hi += timer_out_out;
            end
            chk(hi, (k == 1) ? 2 * (per - dut) : 2 * dut);
            apb(1'b0, `PTMR_FLAGS_ADDR, 32'h0);
            chk(rd & 2, 2);
            if (a < per) chk(rd & 1, 1);
        end
        start(8'h98, 4, 10);
        repeat (30) @(negedge sys_clk_in);
        chk({31'h0, timer_out_out}, 1);
        apb(1'b0, `PTMR_FLAGS_ADDR, 32'h0);
        chk(rd, 3);
        $display("pwm test done");
        for (int i = 0; i < 6; i++) begin
            start({(i == 5) ? 2'b11 : 2'b00, (i < 4) ? 2'(i) : 2'b11, 3'b000, 1'(i < 4)}, 20, (i < 4) ? 5 : 30);
            e0 = ev;
            repeat (30) @(negedge sys_clk_in);
            if (i < 4) chk({31'h0, timer_out_out}, i >= 2);
            repeat (40) @(negedge sys_clk_in);
            apb(1'b0, `PTMR_FLAGS_ADDR, 32'h0);
            chk(rd, (i < 4) ? 1 : 3);
            chk(ev - e0, (i < 4) ? 3 : 4);
        end
        $display("compare test done");
        start(8'hb8, 20, 0);
        repeat (4) @(negedge sys_clk_in);
        chk({31'h0, timer_out_out}, 1);
        repeat (40) @(negedge sys_clk_in);
        chk({31'h0, timer_out_out}, 0);
        apb(1'b0, `PTMR_CTRL0_ADDR, 32'h0);
        chk(rd, 0);
        pins.pulse(1'b1, 3);
        repeat (6) @(negedge sys_clk_in);
        chk({31'h0, timer_out_out}, 1);
        repeat (40) @(negedge sys_clk_in);
        chk({31'h0, timer_out_out}, 0);
        $display("single pulse test done");
        for (int i = 0; i < 8; i++) begin
            start({2'b01, 2'(i >> 1), 2'b00, 1'(i), 1'b0}, 0, 0);
            pins.pulse(!i[0], 4);
            repeat (10) @(negedge sys_clk_in);
            apb(1'b0, `PTMR_FLAGS_ADDR, 32'h0);
            chk(rd & 1, 0);
            repeat (40) @(negedge sys_clk_in);
            pins.pulse(i[0], 4);
            repeat (10) @(negedge sys_clk_in);
            apb(1'b0, `PTMR_FLAGS_ADDR, 32'h0);
            chk(rd & 1, (i >> 1) != 3);
            apb(1'b0, `PTMR_CMPA_LO_ADDR, 32'h0);
            chk(rd != 0, (i >> 1) != 3);
        end
        $display("capture test done");
        tally_and_finish();
    end
endmodule
